// file: prog_guard_defs.svh
// Constants of the programming access guard
`ifndef PROG_GUARD_DEFS_SVH
`define PROG_GUARD_DEFS_SVH

// Command word layout: {data, sector, target, op}
`define CMD_W          17
`define CMD_OP_LSB     0
`define CMD_TGT_LSB    2
`define CMD_SECT_LSB   5
`define CMD_DATA_LSB   9
`define CMD_CNT_W      5

// Sector counts and protection layout
`define PRI_SECTORS    8
`define SEC_SECTORS    4
`define PROT_BITS      12
`define SEC_PROT_BASE  4'h8

// As-delivered values
`define ERASED_BYTE    8'hff
`define CFG_RESET_BIT  1'b0

// Port C pin positions
`define PC_MODE        0
`define PC_TCLK        1
`define PC_STATUS      3
`define PC_ERROR       4
`define PC_SDI         5
`define PC_SDO         6

`endif

// file: prog_guard_pkg.sv
// Types of the programming access guard
`default_nettype none
package prog_guard_pkg;

	typedef enum logic [1:0] {OP_READ, OP_PROG, OP_ERASE_SECT, OP_ERASE_CHIP} op_t;

	typedef enum logic [2:0] {TGT_PRIMARY, TGT_SECONDARY, TGT_LOGIC, TGT_CONFIG,
		TGT_OTP, TGT_PROTECT, TGT_SECURITY, TGT_NONE} tgt_t;

	typedef enum logic [1:0] {PATH_TEST, PATH_INSERT, PATH_MCU} path_t;

	typedef enum logic [1:0] {ST_IDLE, ST_CHECK, ST_WAIT} guard_st_t;

	typedef struct packed {
		logic [7:0] data;
		logic [3:0] sect;
		tgt_t       tgt;
		op_t        op;
	} cmd_t;

	typedef struct packed {
		guard_st_t   st;
		path_t       path;
		cmd_t        cmd;
		logic        tp_s1;
		logic        tp_s2;
		logic        tp_seen;
		logic        ans_tgl;
		logic        ans_err;
		logic [7:0]  ans_data;
		logic        security;
		logic [11:0] prot;
		logic        nvm_req;
		logic        ins_ack;
		logic        ins_ref;
		logic        mcu_ack;
		logic        mcu_ref;
		logic [7:0]  rdata;
	} core_state_t;

	typedef struct packed {
		logic        en1;
		logic        en2;
		logic [16:0] shift;
		logic [4:0]  cnt;
		logic [16:0] cmd;
		logic        req_tgl;
		logic        ans1;
		logic        ans2;
		logic        ans_seen;
		logic        busy;
		logic        err;
		logic [7:0]  out_sh;
	} link_state_t;

endpackage
`default_nettype wire

// file: test_port_if.sv
// Command and answer carrier between test-port link and guard core
`timescale 1ns/10ps
`default_nettype none
interface test_port_if;
	logic [16:0] cmd_word;
	logic        req_tgl;
	logic        ans_tgl;
	logic        ans_err;
	logic [7:0]  ans_data;

	modport link (output cmd_word, output req_tgl, input ans_tgl, input ans_err, input ans_data);
	modport core (input cmd_word, input req_tgl, output ans_tgl, output ans_err, output ans_data);
endinterface
`default_nettype wire

// file: test_port_link.sv
// Serial test-port shifter on the test clock
`timescale 1ns/10ps
`default_nettype none
`include "prog_guard_defs.svh"
module test_port_link
	import prog_guard_pkg::*;
(
	// Link clock and reset
	input  wire logic      test_clk_i,
	input  wire logic      rstn_i,
	// Pin side
	input  wire logic      test_port_en_i,
	input  wire logic      mode_sel_i,
	input  wire logic      sdi_i,
	output logic           sdo_o,
	output logic           status_o,
	output logic           err_o,
	// Core side
	test_port_if.link      lnk
);

	link_state_t s_ff;
	link_state_t nxt_s;

	always_comb begin
		nxt_s = s_ff;
		nxt_s.en1 = test_port_en_i;
		nxt_s.en2 = s_ff.en1;
		nxt_s.ans1 = lnk.ans_tgl;
		nxt_s.ans2 = s_ff.ans1;
		// Answer arrives: load read data for the next frame
		if (s_ff.ans2 != s_ff.ans_seen) begin
			nxt_s.ans_seen = s_ff.ans2;
			nxt_s.busy = 1'b0;
			nxt_s.err = lnk.ans_err;
			nxt_s.out_sh = lnk.ans_data;
		end
		// Frame: mode select high, LSB first
		if (s_ff.en2 && mode_sel_i) begin                          // R6
			nxt_s.shift = {sdi_i, s_ff.shift[16:1]};
			nxt_s.out_sh = {1'b0, s_ff.out_sh[7:1]};
			nxt_s.cnt = s_ff.cnt + 5'h01;
			if (s_ff.cnt == 5'(`CMD_W - 1)) begin
				nxt_s.cmd = {sdi_i, s_ff.shift[16:1]};
				nxt_s.req_tgl = ~s_ff.req_tgl;
				nxt_s.busy = 1'b1;
				nxt_s.cnt = 5'h00;
			end
		end else if (!mode_sel_i) begin
			nxt_s.cnt = 5'h00;
		end
	end

	always_ff @(posedge test_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign lnk.cmd_word = s_ff.cmd;
	assign lnk.req_tgl  = s_ff.req_tgl;
	assign sdo_o        = s_ff.out_sh[0];
	assign status_o     = s_ff.busy;                              // R9
	assign err_o        = s_ff.err;                               // R9

endmodule
`default_nettype wire

// file: prog_guard.sv
// Programming access guard: paths, security lock and sector protection
//
// What this block does
// R1 - Security bit reachable by programmers only
// R2 - Security bit cleared only by chip erase
// R3 - Security set blocks programmer readout
// R4 - Sector protect bits readable, writable by all
// R5 - Each path reaches only its allowed targets
// R6 - Test port erases, programs whole chip alone
// R7 - Only the bank under programming goes busy
// R8 - Test port signals mapped onto Port C
// R9 - Four test-port signals suffice; status optional
// R10 - Delivered state: config zero, memory ones
// R11 - MCU cannot alter a protected sector
`timescale 1ns/10ps
`default_nettype none
`include "prog_guard_defs.svh"
module prog_guard
	import prog_guard_pkg::*;
(
	// Clocks and reset
	input  wire logic        ref_clk_i,
	input  wire logic        rstn_i,
	input  wire logic        test_clk_i,
	// Port C
	input  wire logic        test_port_en_i,
	input  wire logic [7:0]  port_c_in_i,
	input  wire logic [7:0]  alt_out_i,
	input  wire logic [7:0]  alt_oe_i,
	output logic      [7:0]  port_c_out_o,
	output logic      [7:0]  port_c_oe_o,
	// Insertion programmer
	input  wire logic        ins_req_i,
	input  wire logic [16:0] ins_cmd_i,
	output logic             ins_ready_o,
	output logic             ins_ack_o,
	output logic             ins_refused_o,
	output logic      [7:0]  ins_rdata_o,
	// In-application update by the MCU
	input  wire logic        mcu_req_i,
	input  wire logic [16:0] mcu_cmd_i,
	output logic             mcu_ready_o,
	output logic             mcu_ack_o,
	output logic             mcu_refused_o,
	output logic      [7:0]  mcu_rdata_o,
	// Nonvolatile array engine
	output logic             nvm_req_o,
	output logic      [1:0]  nvm_op_o,
	output logic      [2:0]  nvm_tgt_o,
	output logic      [3:0]  nvm_sect_o,
	output logic      [7:0]  nvm_data_o,
	input  wire logic        nvm_done_i,
	input  wire logic [7:0]  nvm_rdata_i,
	// Status
	output logic      [1:0]  bank_busy_o,
	output logic             security_o,
	output logic      [11:0] sect_prot_o
);

	////////////////////////////////////////////////////////////////////////////
	// Test-port link

	test_port_if tp ();

	logic tp_sdo;
	logic tp_status;
	logic tp_err;

	test_port_link u_link (
		.test_clk_i     (test_clk_i),
		.rstn_i         (rstn_i),
		.test_port_en_i (test_port_en_i),
		.mode_sel_i     (port_c_in_i[`PC_MODE]),
		.sdi_i          (port_c_in_i[`PC_SDI]),
		.sdo_o          (tp_sdo),
		.status_o       (tp_status),
		.err_o          (tp_err),
		.lnk            (tp)
	);

	// Pin sharing on Port C
	always_comb begin
		port_c_out_o = alt_out_i;
		port_c_oe_o  = alt_oe_i;
		if (test_port_en_i) begin                                 // R8
			port_c_oe_o[`PC_MODE]   = 1'b0;
			port_c_oe_o[`PC_TCLK]   = 1'b0;
			port_c_oe_o[`PC_SDI]    = 1'b0;
			port_c_out_o[`PC_MODE]  = 1'b0;
			port_c_out_o[`PC_TCLK]  = 1'b0;
			port_c_out_o[`PC_SDI]   = 1'b0;
			port_c_out_o[`PC_STATUS] = tp_status;
			port_c_out_o[`PC_ERROR]  = tp_err;
			port_c_out_o[`PC_SDO]    = tp_sdo;
			port_c_oe_o[`PC_STATUS]  = 1'b1;
			port_c_oe_o[`PC_ERROR]   = 1'b1;
			port_c_oe_o[`PC_SDO]     = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Access policy

	function automatic logic [3:0] prot_index(input cmd_t c);
		if (c.tgt == TGT_SECONDARY) begin
			prot_index = `SEC_PROT_BASE + {2'b00, c.sect[1:0]};
		end else begin
			prot_index = {1'b0, c.sect[2:0]};
		end
	endfunction

	function automatic logic refused(input path_t p, input cmd_t c, input logic sec, input logic [11:0] pr);
		logic mcu;
		logic mem;
		mcu = (p == PATH_MCU);
		mem = (c.tgt == TGT_PRIMARY) || (c.tgt == TGT_SECONDARY);
		refused = 1'b0;
		if (c.op == OP_ERASE_CHIP) begin
			refused = mcu;                                        // R6
		end else begin
			unique case (c.tgt)
				TGT_SECURITY: refused = mcu || (c.op == OP_ERASE_SECT);         // R1 R2
				TGT_LOGIC, TGT_CONFIG: refused = mcu;                             // R5
				TGT_OTP: refused = (p == PATH_TEST);                             // R5
				TGT_PROTECT: refused = (c.sect >= 4'(`PROT_BITS)) || (c.op == OP_ERASE_SECT); // R4
				TGT_PRIMARY, TGT_SECONDARY: refused = 1'b0;                       // R5
				default: refused = 1'b1;
			endcase
			if (mem && mcu && c.op != OP_READ && pr[prot_index(c)]) begin
				refused = 1'b1;                                   // R11
			end
			if (c.op == OP_READ && sec && !mcu && c.tgt != TGT_PROTECT && c.tgt != TGT_SECURITY) begin
				refused = 1'b1;                                   // R3
			end
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Request handling

	core_state_t s_ff;
	core_state_t nxt_s;
	logic        take_test;
	logic        take_ins;
	logic        take_mcu;
	logic        rd_prot;

	assign take_test   = (s_ff.st == ST_IDLE) && (s_ff.tp_s2 != s_ff.tp_seen);
	assign ins_ready_o = (s_ff.st == ST_IDLE) && !take_test;
	assign take_ins    = ins_ready_o && ins_req_i;
	assign mcu_ready_o = ins_ready_o && !ins_req_i;
	assign take_mcu    = mcu_ready_o && mcu_req_i;
	assign rd_prot     = s_ff.prot[s_ff.cmd.sect];

	always_comb begin
		logic       done;
		logic       err;
		logic [7:0] rd;
		done = 1'b0;
		err  = 1'b0;
		rd   = 8'h00;
		nxt_s = s_ff;
		nxt_s.tp_s1   = tp.req_tgl;
		nxt_s.tp_s2   = s_ff.tp_s1;
		nxt_s.nvm_req = 1'b0;
		nxt_s.ins_ack = 1'b0;
		nxt_s.ins_ref = 1'b0;
		nxt_s.mcu_ack = 1'b0;
		nxt_s.mcu_ref = 1'b0;
		unique case (s_ff.st)
			ST_IDLE: begin
				if (take_test) begin
					nxt_s.tp_seen = s_ff.tp_s2;
					nxt_s.path = PATH_TEST;
					nxt_s.cmd  = cmd_t'(tp.cmd_word);
					nxt_s.st   = ST_CHECK;
				end else if (take_ins) begin
					nxt_s.path = PATH_INSERT;
					nxt_s.cmd  = cmd_t'(ins_cmd_i);
					nxt_s.st   = ST_CHECK;
				end else if (take_mcu) begin
					nxt_s.path = PATH_MCU;
					nxt_s.cmd  = cmd_t'(mcu_cmd_i);
					nxt_s.st   = ST_CHECK;
				end
			end
			ST_CHECK: begin
				if (refused(s_ff.path, s_ff.cmd, s_ff.security, s_ff.prot)) begin
					done = 1'b1;
					err  = 1'b1;
				end else if (s_ff.cmd.op == OP_ERASE_CHIP) begin
					nxt_s.security = `CFG_RESET_BIT;              // R2
					nxt_s.prot     = '0;                          // R10
					nxt_s.nvm_req  = 1'b1;                        // R6
					nxt_s.st       = ST_WAIT;
				end else if (s_ff.cmd.tgt == TGT_SECURITY) begin
					done = 1'b1;
					rd   = {7'h00, s_ff.security};
					if (s_ff.cmd.op == OP_PROG) begin
						nxt_s.security = s_ff.cmd.data[0];
						if (!s_ff.cmd.data[0]) begin
							nxt_s.security = s_ff.security;       // R2
						end
					end
				end else if (s_ff.cmd.tgt == TGT_PROTECT) begin
					done = 1'b1;
					rd   = {7'h00, rd_prot};
					if (s_ff.cmd.op == OP_PROG) begin
						nxt_s.prot[s_ff.cmd.sect] = s_ff.cmd.data[0]; // R4
					end
				end else begin
					nxt_s.nvm_req = 1'b1;
					nxt_s.st      = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (nvm_done_i) begin
					done = 1'b1;
					rd   = (s_ff.cmd.op == OP_READ) ? nvm_rdata_i : 8'h00;
				end
			end
			default: nxt_s.st = ST_IDLE;
		endcase
		if (done) begin
			nxt_s.st    = ST_IDLE;
			nxt_s.rdata = rd;
			unique case (s_ff.path)
				PATH_TEST: begin
					nxt_s.ans_data = rd;
					nxt_s.ans_err  = err;
					nxt_s.ans_tgl  = ~s_ff.ans_tgl;
				end
				PATH_INSERT: begin
					nxt_s.ins_ack = ~err;
					nxt_s.ins_ref = err;
				end
				default: begin
					nxt_s.mcu_ack = ~err;
					nxt_s.mcu_ref = err;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s_ff <= '0;                                           // R10
		end else begin
			s_ff <= nxt_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign tp.ans_tgl    = s_ff.ans_tgl;
	assign tp.ans_err    = s_ff.ans_err;
	assign tp.ans_data   = s_ff.ans_data;
	assign ins_ack_o     = s_ff.ins_ack;
	assign ins_refused_o = s_ff.ins_ref;
	assign ins_rdata_o   = s_ff.rdata;
	assign mcu_ack_o     = s_ff.mcu_ack;
	assign mcu_refused_o = s_ff.mcu_ref;
	assign mcu_rdata_o   = s_ff.rdata;
	assign nvm_req_o     = s_ff.nvm_req;
	assign nvm_op_o      = s_ff.cmd.op;
	assign nvm_tgt_o     = s_ff.cmd.tgt;
	assign nvm_sect_o    = s_ff.cmd.sect;
	assign nvm_data_o    = (s_ff.cmd.op == OP_PROG) ? s_ff.cmd.data : `ERASED_BYTE; // R10
	assign security_o    = s_ff.security;
	assign sect_prot_o   = s_ff.prot;

	// Only the bank being altered is busy; the other stays fetchable, except in a chip erase, which makes both busy
	always_comb begin
		bank_busy_o = 2'b00;
		if (s_ff.st == ST_WAIT && s_ff.cmd.op != OP_READ) begin
			bank_busy_o[0] = (s_ff.cmd.tgt == TGT_PRIMARY) || (s_ff.cmd.op == OP_ERASE_CHIP);   // R7
			bank_busy_o[1] = (s_ff.cmd.tgt == TGT_SECONDARY) || (s_ff.cmd.op == OP_ERASE_CHIP); // R7
		end
	end

endmodule
`default_nettype wire

// file: prog_guard_asserts.sv
// Port checks of the programming access guard
`timescale 1ns/10ps
`default_nettype none
module prog_guard_asserts (
	// Clock and reset
	input wire logic        ref_clk_i,
	input wire logic        rstn_i,
	// Pins
	input wire logic        test_port_en_i,
	input wire logic [7:0]  alt_out_i,
	input wire logic [7:0]  alt_oe_i,
	input wire logic [7:0]  port_c_out_o,
	input wire logic [7:0]  port_c_oe_o,
	// MCU path
	input wire logic        mcu_req_i,
	input wire logic [16:0] mcu_cmd_i,
	input wire logic        mcu_ready_o,
	input wire logic        mcu_refused_o,
	input wire logic [7:0]  mcu_rdata_o,
	// Engine and status
	input wire logic        nvm_req_o,
	input wire logic [1:0]  nvm_op_o,
	input wire logic [2:0]  nvm_tgt_o,
	input wire logic [1:0]  bank_busy_o,
	input wire logic [11:0] sect_prot_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rstn_i);
	////////////////////////////////
	sequence s_take;
		mcu_req_i && mcu_ready_o;
	endsequence
	sequence s_refuse;
		##2 mcu_refused_o && !nvm_req_o;
	endsequence
	AST_MCU_SEC: assert property (s_take ##0 mcu_cmd_i[4:2] == 3'h6 |-> s_refuse)
		else $error("mcu reached security");
	AST_MCU_PLD: assert property (s_take ##0 mcu_cmd_i[4:2] inside {3'h2, 3'h3} |-> s_refuse)
		else $error("mcu reached logic or config");
	AST_MCU_PROT: assert property (s_take ##0 (mcu_cmd_i[1:0] == 2'h1 && mcu_cmd_i[4:2] == 3'h0
		&& !mcu_cmd_i[8] && sect_prot_o[mcu_cmd_i[7:5]]) |-> s_refuse)
		else $error("protected sector changed");
	AST_BUSY_PRI: assert property (nvm_req_o && nvm_op_o inside {2'h1, 2'h2} && nvm_tgt_o == 3'h0
		|-> ##[0:1] bank_busy_o == 2'h1)
		else $error("wrong bank busy");
	AST_READ_FREE: assert property (nvm_req_o && nvm_op_o == 2'h0 |-> bank_busy_o == 2'h0)
		else $error("busy on read");
	AST_PINS_OFF: assert property (!test_port_en_i |-> port_c_out_o == alt_out_i && port_c_oe_o == alt_oe_i)
		else $error("pins not passed through");
	AST_PINS_ON: assert property (test_port_en_i |-> {port_c_oe_o[6:3], port_c_oe_o[1:0]} == 6'h2c
		&& port_c_out_o[7] == alt_out_i[7] && port_c_out_o[2] == alt_out_i[2])
		else $error("test pins misplaced");
	AST_REF_ZERO: assert property (mcu_refused_o |-> mcu_rdata_o == 8'h00)
		else $error("refused data not zero");
endmodule
bind prog_guard prog_guard_asserts u_prog_guard_asserts (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
	.test_port_en_i(test_port_en_i), .alt_out_i(alt_out_i), .alt_oe_i(alt_oe_i),
	.port_c_out_o(port_c_out_o), .port_c_oe_o(port_c_oe_o), .mcu_req_i(mcu_req_i),
	.mcu_cmd_i(mcu_cmd_i), .mcu_ready_o(mcu_ready_o), .mcu_refused_o(mcu_refused_o),
	.mcu_rdata_o(mcu_rdata_o), .nvm_req_o(nvm_req_o), .nvm_op_o(nvm_op_o), .nvm_tgt_o(nvm_tgt_o),
	.bank_busy_o(bank_busy_o), .sect_prot_o(sect_prot_o));
`default_nettype wire

// file: nvm_engine_model.sv
// Array engine model: answers each request four cycles later
`timescale 1ns/10ps
`default_nettype none
module nvm_engine_model (
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rstn_i,
	// Engine handshake
	input  wire logic       req_i,
	output logic            done_o,
	output logic      [7:0] rdata_o
);
	logic [1:0] cnt_ff;
	////////////////////////////////
	// Data toggles outside the done cycle
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt_ff  <= 2'h0;
			done_o  <= 1'b0;
			rdata_o <= 8'h00;
		end else begin
			cnt_ff  <= req_i ? 2'h1 : (cnt_ff == 2'h0 ? 2'h0 : cnt_ff + 2'h1);
			done_o  <= cnt_ff == 2'h3;
			rdata_o <= cnt_ff == 2'h3 ? 8'h5a : ~rdata_o;
		end
	end
endmodule
`default_nettype wire

// file: prog_guard_tb.sv
// Self-checking bench of the programming access guard
`timescale 1ns/10ps
`default_nettype none
module prog_guard_tb
	import prog_guard_pkg::*;
;
	logic        clk, rstn, tclk, en, mode, sdi, sec;
	logic        ireq, irdy, iack, iref, mreq, mrdy, mack, mref, nreq, ndone;
	logic [16:0] icmd, mcmd;
	logic [7:0]  ird, mrd, nrd, pout, ndat;
	logic [3:0]  nsect;
	logic [11:0] prot;
	int          error_cnt, checks, cyc;
	////////////////////////////////
	prog_guard u_prog_guard (.ref_clk_i(clk), .rstn_i(rstn), .test_clk_i(tclk), .test_port_en_i(en),
		.port_c_in_i({2'h0, sdi, 3'h0, tclk, mode}), .alt_out_i(8'h96), .alt_oe_i(8'hc3),
		.port_c_out_o(pout), .port_c_oe_o(), .ins_req_i(ireq), .ins_cmd_i(icmd), .ins_ready_o(irdy),
		.ins_ack_o(iack), .ins_refused_o(iref), .ins_rdata_o(ird), .mcu_req_i(mreq), .mcu_cmd_i(mcmd),
		.mcu_ready_o(mrdy), .mcu_ack_o(mack), .mcu_refused_o(mref), .mcu_rdata_o(mrd),
		.nvm_req_o(nreq), .nvm_op_o(), .nvm_tgt_o(), .nvm_sect_o(nsect), .nvm_data_o(ndat), .nvm_done_i(ndone),
		.nvm_rdata_i(nrd), .bank_busy_o(), .security_o(sec), .sect_prot_o(prot));
	nvm_engine_model u_nvm_engine_model (.clk_i(clk), .rstn_i(rstn), .req_i(nreq), .done_o(ndone),
		.rdata_o(nrd));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 8000) begin
			error_cnt++;
			report_and_stop();
		end
	end
	function automatic logic [16:0] mk(op_t o, tgt_t t, logic [3:0] s, logic [7:0] d);
		return {d, s, t, o};
	endfunction
	task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// Holds the request until the edge that takes it
	task automatic req(input logic p, input logic [16:0] c, input logic r);
		int n;
		n = 0;
		{mreq, ireq} = {p, !p};
		{mcmd, icmd} = {c, c};
		while ((p ? mrdy : irdy) !== 1'b1 && n < 50) begin
			@(posedge clk);
			#1 n++;
		end
		@(posedge clk);
		#1 {mreq, ireq} = 2'h0;
		while ((p ? mack | mref : iack | iref) !== 1'b1 && n < 99) begin
			@(posedge clk);
			#1 n++;
		end
		cmp(12'(p ? {mack, mref} : {iack, iref}), 12'({!r, r}));
		if (c[1:0] == 2'h0 || r)
			cmp(12'(p ? mrd : ird), r ? 12'h0 : 12'h5a);
		if (c[1:0] != 2'h0)
			cmp({nsect, ndat}, {c[8:5], ((c[1:0] == 2'h1) ? c[16:9] : 8'hff)});
	endtask
	task automatic pulse(input int k);
		repeat (k) begin
			#24 tclk = 1'b1;
			#24 tclk = 1'b0;
		end
	endtask
	task automatic frame(input logic [16:0] c, input logic e);
		for (int i = 0; i < 17; i++) begin
			mode = 1'b1;
			sdi = c[i];
			pulse(1);
		end
		mode = 1'b0;
		pulse(12);
		cmp(12'({pout[3], pout[4]}), 12'({1'b0, e}));
	endtask
	////////////////////////////////
	task automatic t_ins();
		req(0, mk(OP_READ, TGT_PRIMARY, 4'h3, 8'h00), 0);
		req(0, mk(OP_PROG, TGT_LOGIC, 4'h0, 8'h33), 0);
		req(0, mk(OP_PROG, TGT_CONFIG, 4'h0, 8'h01), 0);
		req(0, mk(OP_PROG, TGT_OTP, 4'h0, 8'h44), 0);
		req(0, mk(OP_PROG, TGT_PROTECT, 4'h9, 8'h01), 0);
		cmp(prot, 12'h200);
		req(0, mk(OP_PROG, TGT_SECURITY, 4'h0, 8'h01), 0);
		req(0, mk(OP_PROG, TGT_SECURITY, 4'h0, 8'h00), 0);
		req(0, mk(OP_ERASE_SECT, TGT_SECURITY, 4'h0, 8'h00), 1);
		cmp(12'(sec), 12'h1);
		req(0, mk(OP_READ, TGT_SECONDARY, 4'h1, 8'h00), 1);
		req(0, mk(OP_ERASE_CHIP, TGT_NONE, 4'h0, 8'h00), 0);
		cmp({3'h0, sec, prot[7:0]}, 12'h0);
	endtask
	task automatic t_mcu();
		req(1, mk(OP_PROG, TGT_PROTECT, 4'h0, 8'h01), 0);
		cmp(prot, 12'h001);
		req(1, mk(OP_PROG, TGT_PRIMARY, 4'h0, 8'h12), 1);
		req(1, mk(OP_ERASE_SECT, TGT_PRIMARY, 4'h0, 8'h00), 1);
		req(1, mk(OP_PROG, TGT_PRIMARY, 4'h1, 8'h12), 0);
		req(1, mk(OP_PROG, TGT_SECONDARY, 4'h2, 8'h34), 0);
		req(1, mk(OP_PROG, TGT_OTP, 4'h0, 8'h55), 0);
		req(1, mk(OP_PROG, TGT_LOGIC, 4'h0, 8'h00), 1);
		req(1, mk(OP_READ, TGT_CONFIG, 4'h0, 8'h00), 1);
		req(1, mk(OP_PROG, TGT_SECURITY, 4'h0, 8'h01), 1);
		req(1, mk(OP_ERASE_CHIP, TGT_NONE, 4'h0, 8'h00), 1);
		cmp(12'(sec), 12'h0);
	endtask
	task automatic t_port();
		en = 1'b1;
		pulse(2);
		frame(mk(OP_PROG, TGT_OTP, 4'h0, 8'h00), 1);
		frame(mk(OP_PROG, TGT_PROTECT, 4'h3, 8'h01), 0);
		cmp(prot, 12'h009);
		frame(mk(OP_READ, TGT_PROTECT, 4'h3, 8'h00), 0);
		cmp(12'(pout[6]), 12'h1);
		frame(mk(OP_ERASE_CHIP, TGT_NONE, 4'h0, 8'h00), 0);
		cmp(prot, 12'h000);
	endtask
	task automatic report_and_stop();
		if (error_cnt == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		{rstn, tclk, en, mode, sdi, ireq, mreq} = 7'h0;
		{icmd, mcmd} = 34'h0;
		fork
			repeat (20) @(posedge clk);
			pulse(3);
		join
		#1 rstn = 1'b1;
		cmp({3'h0, sec, pout}, 12'h096);
		cmp(prot, 12'h000);
		t_ins();
		t_mcu();
		t_port();
		report_and_stop();
	end
endmodule
`default_nettype wire
